// *** design/nipc_map.svh ***
// Register indices, reset values, field positions and vector addresses
`ifndef NIPC_MAP_SVH
`define NIPC_MAP_SVH
`define NIPC_IDX_PRI0 8'h24
`define NIPC_IDX_PRI1 8'h25
`define NIPC_IDX_PRI2 8'h26
`define NIPC_IDX_PRI3 8'h27
`define NIPC_IDX_SENS 8'h28
`define NIPC_IDX_STAT 8'h29
`define NIPC_PRI_RST 8'hff
`define NIPC_PRI3_RO 8'hf0
`define NIPC_SENS_RST 8'h00
`define NIPC_SENS_WMASK 8'hfc
`define NIPC_SENS_IS1 7
`define NIPC_SENS_IPB 5
`define NIPC_SENS_IS2 4
`define NIPC_SENS_IPA 2
`define NIPC_CODE_LVL0 2'b10
`define NIPC_CODE_LVL3 2'b11
`define NIPC_VEC_RESET 16'hfffe
`define NIPC_VEC_TRAP 16'hfffc
`define NIPC_VEC_SLOT0 16'hfffa
`define NIPC_WAKE_ACTIVE 14'h00be
`define NIPC_WAKE_FULL 14'h00bc
`endif

// *** design/nipc_pkg.sv ***
// Types shared by the nested interrupt priority controller
package nipc_pkg;
	typedef enum logic [1:0] {
		nipc_fall_low = 2'b00,
		nipc_rise = 2'b01,
		nipc_fall = 2'b10,
		nipc_both = 2'b11
	} nipc_sens_e;
	typedef logic [1:0] nipc_pri_t;
	typedef logic [13:0] nipc_slots_t;
endpackage

// *** design/nipc_ctrl.sv ***
// Nested interrupt priority controller with AHB-Lite register slave
//
// Local design decisions: the AHB-Lite register port and the register offsets.
`include "nipc_map.svh"
`timescale 1ns/100ps
module nipc_ctrl
	import nipc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [3:0] port_a_pins,
	input wire logic [2:0] port_f_pins,
	input wire logic [7:0] port_b_pins,
	input wire logic timebase_req,
	input wire logic safe_osc_req,
	input wire logic spi_req,
	input wire logic timer_a_req,
	input wire logic timer_b_req,
	input wire logic async_serial_req,
	input wire logic voltage_det_req,
	input wire logic enable_interrupts_instr,
	input wire logic disable_interrupts_instr,
	input wire logic halt_instr,
	input wire logic wait_for_interrupt_instr,
	input wire logic trap_instr,
	input wire logic interrupt_return_instr,
	input wire logic pop_condition_code_instr,
	input wire logic [1:0] popped_priority,
	input wire logic service_ack,
	input wire logic in_full_halt,
	input wire logic in_active_halt,
	output logic current_priority_hi,
	output logic current_priority_lo,
	output logic irq_req,
	output logic [3:0] irq_slot,
	output logic [15:0] irq_vector,
	output logic halt_wake,
	output logic jump_if_masked,
	output logic jump_if_not_masked
);

	// Level number of a priority code
	function automatic logic [1:0] nipc_lvl(input nipc_pri_t c);
		logic [1:0] l;
		unique case (c)
			2'b10: l = 2'd0;
			2'b01: l = 2'd1;
			2'b00: l = 2'd2;
			2'b11: l = 2'd3;
		endcase
		return l;
	endfunction

	// Byte address of a register index
	function automatic logic [9:0] nipc_addr(input logic [7:0] idx);
		return {idx, 2'b00};
	endfunction

	// Field merge that refuses the level 0 code
	function automatic logic [7:0] nipc_merge(input logic [7:0] old, input logic [7:0] wr);
		logic [7:0] r;
		r = old;
		for (int k = 0; k < 4; k++) begin
			if (wr[2*k +: 2] != `NIPC_CODE_LVL0) begin
				r[2*k +: 2] = wr[2*k +: 2];
			end
		end
		return r;
	endfunction

	logic [7:0] vector_priority_regs [4];
	logic [7:0] external_sensitivity_reg;
	nipc_pri_t cur;
	logic ph_valid;
	logic ph_write;
	logic [9:0] ph_addr;
	logic rd_stage;
	logic [3:0] pa_s1, pa_s2;
	logic [2:0] pf_s1, pf_s2;
	logic [7:0] pb_s1, pb_s2;
	logic [3:0] grp_prev;
	logic [3:0] edge_latch;
	logic [3:0] grp_raw;
	logic [3:0] grp_inv;
	logic [3:0] grp_hit;
	logic [3:0] grp_low;
	logic [3:0] grp_pend;
	nipc_sens_e grp_mode [4];
	nipc_slots_t pend;
	nipc_slots_t elig;
	logic [27:0] fields;
	logic pick_found;
	logic [3:0] pick_slot;
	logic wr_go;
	logic sens_wr;
	logic sens_clr;
	logic ack_ok;

	// Address phase capture; reads take one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr <= 10'h000;
		end else if (hready) begin
			ph_valid <= hsel & htrans[1];
			ph_write <= hwrite;
			ph_addr <= haddr[9:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_stage <= 1'b0;
		end else begin
			rd_stage <= hready & hsel & htrans[1] & ~hwrite;
		end
	end

	assign hreadyout = ~rd_stage;
	assign hresp = 1'b0;
	assign wr_go = ph_valid & ph_write;
	assign sens_wr = wr_go & (ph_addr == nipc_addr(`NIPC_IDX_SENS))
		& (cur == `NIPC_CODE_LVL3);
	assign sens_clr = sens_wr
		& ((hwdata[7:0] & `NIPC_SENS_WMASK) != external_sensitivity_reg);

	// Priority registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 4; i++) begin
				vector_priority_regs[i] <= `NIPC_PRI_RST;
			end
		end else if (wr_go) begin
			for (int i = 0; i < 4; i++) begin
				if (ph_addr == nipc_addr(`NIPC_IDX_PRI0 + 8'(i))) begin
					vector_priority_regs[i] <= nipc_merge(vector_priority_regs[i], hwdata[7:0])
						| ((i == 3) ? `NIPC_PRI3_RO : 8'h00);
				end
			end
		end
	end

	// Sensitivity register, written only at level 3
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			external_sensitivity_reg <= `NIPC_SENS_RST;
		end else if (sens_wr) begin
			external_sensitivity_reg <= hwdata[7:0] & `NIPC_SENS_WMASK;
		end
	end

	// Read data, loaded during the wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_stage) begin
			hrdata <= 32'h0000_0000;
			for (int i = 0; i < 4; i++) begin
				if (ph_addr == nipc_addr(`NIPC_IDX_PRI0 + 8'(i))) begin
					hrdata <= {24'h00_0000, vector_priority_regs[i]};
				end
			end
			if (ph_addr == nipc_addr(`NIPC_IDX_SENS)) begin
				hrdata <= {24'h00_0000, external_sensitivity_reg};
			end
			if (ph_addr == nipc_addr(`NIPC_IDX_STAT)) begin
				hrdata <= {2'h0, pend, 4'h0, irq_slot, 3'h0, irq_req, 2'h0, cur};
			end
		end
	end

	// Two-flop pin synchronisers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pa_s1 <= 4'hf;
			pa_s2 <= 4'hf;
			pf_s1 <= 3'h7;
			pf_s2 <= 3'h7;
			pb_s1 <= 8'hff;
			pb_s2 <= 8'hff;
		end else begin
			pa_s1 <= port_a_pins;
			pa_s2 <= pa_s1;
			pf_s1 <= port_f_pins;
			pf_s2 <= pf_s1;
			pb_s1 <= port_b_pins;
			pb_s2 <= pb_s1;
		end
	end

	// Group levels, polarity and modes
	always_comb begin
		grp_raw = {|pb_s2[7:4], |pb_s2[3:0], |pf_s2, |pa_s2};
		grp_inv = {1'b0, external_sensitivity_reg[`NIPC_SENS_IPB], 1'b0,
			external_sensitivity_reg[`NIPC_SENS_IPA]};
		grp_mode[0] = nipc_sens_e'(external_sensitivity_reg[`NIPC_SENS_IS2 -: 2]);
		grp_mode[1] = nipc_sens_e'(external_sensitivity_reg[`NIPC_SENS_IS2 -: 2]);
		grp_mode[2] = nipc_sens_e'(external_sensitivity_reg[`NIPC_SENS_IS1 -: 2]);
		grp_mode[3] = nipc_sens_e'(external_sensitivity_reg[`NIPC_SENS_IS1 -: 2]);
		for (int g = 0; g < 4; g++) begin
			logic rise;
			logic fall;
			rise = 1'b0;
			fall = 1'b0;
			// Inversion swaps the edges, so a polarity change makes no edge
			rise = grp_inv[g] ? (grp_prev[g] & ~grp_raw[g]) : (~grp_prev[g] & grp_raw[g]);
			fall = grp_inv[g] ? (~grp_prev[g] & grp_raw[g]) : (grp_prev[g] & ~grp_raw[g]);
			grp_low[g] = ~(grp_raw[g] ^ grp_inv[g]);
			unique case (grp_mode[g])
				nipc_fall_low: grp_hit[g] = fall;
				nipc_rise: grp_hit[g] = rise;
				nipc_fall: grp_hit[g] = fall;
				nipc_both: grp_hit[g] = rise | fall;
			endcase
			grp_pend[g] = edge_latch[g] | ((grp_mode[g] == nipc_fall_low) & grp_low[g]);
		end
	end

	// Edge latches: a new edge wins over a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			grp_prev <= 4'hf;
			edge_latch <= 4'h0;
		end else begin
			grp_prev <= grp_raw;
			for (int g = 0; g < 4; g++) begin
				if (grp_hit[g]) begin
					edge_latch[g] <= 1'b1;
				end else if (sens_clr || (ack_ok && irq_slot == 4'(g + 2))) begin
					edge_latch[g] <= 1'b0;
				end
			end
		end
	end

	// Pending sources in fixed slot order
	always_comb begin
		pend = '0;
		pend[1] = timebase_req | safe_osc_req;
		pend[5:2] = grp_pend;
		pend[7] = spi_req;
		pend[8] = timer_a_req;
		pend[9] = timer_b_req;
		pend[10] = async_serial_req;
		pend[11] = voltage_det_req;
		elig = pend;
		if (in_full_halt) begin
			elig = pend & `NIPC_WAKE_FULL;
		end else if (in_active_halt) begin
			elig = pend & `NIPC_WAKE_ACTIVE;
		end
		fields = {vector_priority_regs[3][3:0], vector_priority_regs[2],
			vector_priority_regs[1], vector_priority_regs[0]};
	end

	// Arbiter: higher level first, lower slot on ties
	always_comb begin
		logic [1:0] best;
		best = 2'd0;
		pick_found = 1'b0;
		pick_slot = 4'h0;
		for (int s = 0; s < 14; s++) begin
			// Requests that cannot win are left pending
			if (elig[s] && nipc_lvl(fields[2*s +: 2]) > nipc_lvl(cur)
				&& (!pick_found || nipc_lvl(fields[2*s +: 2]) > best)) begin
				pick_found = 1'b1;
				best = nipc_lvl(fields[2*s +: 2]);
				pick_slot = 4'(s);
			end
		end
	end

	assign ack_ok = service_ack & irq_req;

	// Request, slot, vector and wake outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_req <= 1'b0;
			irq_slot <= 4'h0;
			irq_vector <= `NIPC_VEC_RESET;
			halt_wake <= 1'b0;
		end else begin
			// Raised field of a pending source beats the running level
			irq_req <= pick_found & ~ack_ok;
			irq_slot <= pick_slot;
			if (trap_instr) begin
				irq_vector <= `NIPC_VEC_TRAP;
			end else begin
				irq_vector <= `NIPC_VEC_SLOT0 - {11'h000, pick_slot, 1'b0};
			end
			halt_wake <= (in_full_halt | in_active_halt) & pick_found;
		end
	end

	// Current priority bits of the condition code
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur <= `NIPC_CODE_LVL3;
		end else if (interrupt_return_instr || pop_condition_code_instr) begin
			cur <= popped_priority;
		end else if (trap_instr || disable_interrupts_instr) begin
			cur <= `NIPC_CODE_LVL3;
		end else if (enable_interrupts_instr || halt_instr || wait_for_interrupt_instr) begin
			cur <= `NIPC_CODE_LVL0;
		end else if (ack_ok) begin
			cur <= fields[2*irq_slot +: 2];
		end
	end
	// Values held until the next instruction, return or accepted acknowledge

	assign current_priority_hi = cur[1];
	assign current_priority_lo = cur[0];
	assign jump_if_masked = (cur == `NIPC_CODE_LVL3);
	assign jump_if_not_masked = (cur != `NIPC_CODE_LVL3);

endmodule

// *** test/nipc_asserts.sv ***
// Port checker for the nested priority controller
`timescale 1ns/100ps
module nipc_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic enable_interrupts_instr,
	input wire logic disable_interrupts_instr,
	input wire logic trap_instr,
	input wire logic interrupt_return_instr,
	input wire logic pop_condition_code_instr,
	input wire logic [1:0] popped_priority,
	input wire logic service_ack,
	input wire logic current_priority_hi,
	input wire logic current_priority_lo,
	input wire logic irq_req,
	input wire logic [3:0] irq_slot,
	input wire logic [15:0] irq_vector,
	input wire logic jump_if_masked,
	input wire logic jump_if_not_masked
);
	logic [1:0] cur;
	logic up;
	logic set3;
	// Current level and instruction precedence
	assign cur = {current_priority_hi, current_priority_lo};
	assign up = interrupt_return_instr | pop_condition_code_instr;
	assign set3 = disable_interrupts_instr | trap_instr;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_jump_masked: assert property (jump_if_masked == (cur == 2'b11))
		else $error("masked jump wrong");
	a_jump_pair: assert property (jump_if_not_masked != jump_if_masked)
		else $error("jump pair wrong");
	a_enable_lvl: assert property (enable_interrupts_instr && !up && !set3 |=> cur == 2'b10)
		else $error("enable level wrong");
	a_disable_lvl: assert property (set3 && !up |=> cur == 2'b11)
		else $error("disable level wrong");
	a_return_pop: assert property (up |=> cur == $past(popped_priority))
		else $error("popped level lost");
	a_trap_vec: assert property (trap_instr |=> irq_vector == 16'hfffc)
		else $error("trap vector wrong");
	a_slot_vec: assert property (irq_req && !$past(trap_instr) |->
		irq_vector == 16'hfffa - 16'(2 * irq_slot)) else $error("slot vector wrong");
	a_ack_drop: assert property (service_ack && irq_req |=> !irq_req)
		else $error("request held after ack");
	c_ack: cover property (service_ack && irq_req);
	c_trap: cover property (trap_instr);
	c_ret: cover property (up);
endmodule

bind nipc_ctrl nipc_asserts i_nipc_asserts (.hclk, .hresetn, .enable_interrupts_instr,
	.disable_interrupts_instr, .trap_instr, .interrupt_return_instr, .pop_condition_code_instr,
	.popped_priority, .service_ack, .current_priority_hi, .current_priority_lo, .irq_req,
	.irq_slot, .irq_vector, .jump_if_masked, .jump_if_not_masked);

// *** test/nipc_core_model.sv ***
// Core model that acknowledges a standing request dly+1 cycles after it rises
`timescale 1ns/100ps
module nipc_core_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic irq_req,
	input wire logic [3:0] dly,
	output logic service_ack
);
	logic [3:0] cnt;
	// One acknowledge per request, prompt or slow
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt <= 4'h0;
			service_ack <= 1'b0;
		end else begin
			service_ack <= irq_req && !service_ack && cnt == dly;
			cnt <= (irq_req && !service_ack) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule

// *** test/test_nipc_ctrl.sv ***
// Self-checking bench for the nested priority controller
`timescale 1ns/100ps
module test_nipc_ctrl;
	logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0, hreadyout, hresp;
	logic [1:0] htrans = '0, popped_priority = '0, cv, jv;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [3:0] port_a_pins = 4'hf, dly = '0, irq_slot;
	logic [2:0] port_f_pins = 3'h7;
	logic [7:0] port_b_pins = 8'hff, o, d;
	logic [6:0] iv = '0;
	logic spi_req = '0, timer_a_req = '0, timer_b_req = '0, async_serial_req = '0;
	logic in_full_halt = '0, service_ack, current_priority_hi, current_priority_lo;
	logic irq_req, halt_wake, jump_if_masked, jump_if_not_masked;
	logic [15:0] irq_vector;
	logic [22:0] snap;
	logic [31:0] exp_q[$];
	// Instruction table: pulses, popped level, expected level
	logic [10:0] tt[8] = '{11'h012, 11'h023, 11'h042, 11'h103, 11'h082, 11'h205, 11'h400,
		11'h22a};
	int seed = 32'hdf94, error_cnt = 0, tests_run = 0;
	bit rd_ph = 0;
	nipc_ctrl i_nipc_ctrl (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .port_a_pins, .port_f_pins,
		.port_b_pins, .timebase_req(1'b0), .safe_osc_req(1'b0), .spi_req, .timer_a_req,
		.timer_b_req, .async_serial_req, .voltage_det_req(1'b0),
		.enable_interrupts_instr(iv[0]), .disable_interrupts_instr(iv[1]), .halt_instr(iv[2]),
		.wait_for_interrupt_instr(iv[3]), .trap_instr(iv[4]), .interrupt_return_instr(iv[5]),
		.pop_condition_code_instr(iv[6]), .popped_priority, .service_ack, .in_full_halt,
		.in_active_halt(1'b0), .current_priority_hi, .current_priority_lo, .irq_req,
		.irq_slot, .irq_vector, .halt_wake, .jump_if_masked, .jump_if_not_masked);
	nipc_core_model i_nipc_core_model (.hclk, .hresetn, .irq_req, .dly, .service_ack);
	// Bus clock
	always #25 hclk = ~hclk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Wait for ready (0), request (1) or no request (2), then snapshot
	task automatic wt(input int k);
		int n;
		n = 0;
		@(negedge hclk);
		while ((k == 0 ? hreadyout : k == 1 ? irq_req : !irq_req) !== 1'b1) begin
			if (++n > 60) begin
				error_cnt++;
				conclude;
			end
			@(negedge hclk);
		end
		snap = {current_priority_hi, current_priority_lo, halt_wake, irq_slot, irq_vector};
		@(posedge hclk);
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] dt);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		wt(0);
		htrans <= 2'b00;
		hwdata <= {24'h0, dt};
		wt(0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(a, 1'b0, 8'h00);
	endtask
	task automatic pi(input logic [6:0] v, input logic [1:0] p);
		iv <= v;
		popped_priority <= p;
		@(posedge hclk);
		iv <= '0;
		@(negedge hclk);
		cv = {current_priority_hi, current_priority_lo};
		jv = {jump_if_masked, jump_if_not_masked};
		@(posedge hclk);
	endtask
	// Field update with the level 0 code dropped
	function automatic logic [7:0] mg(input logic [7:0] old, input logic [7:0] nw);
		for (int i = 0; i < 8; i += 2)
			if (nw[i+:2] == 2'b10)
				nw[i+:2] = old[i+:2];
		return nw;
	endfunction
	// Compare each completed read with the oldest noted value
	always @(posedge hclk) begin
		if (rd_ph && hreadyout) begin
			chk(hrdata, exp_q.pop_front());
			chk(hresp, 1'b0);
			rd_ph = 0;
		end
		if (hsel && htrans[1] && !hwrite && hreadyout)
			rd_ph = 1;
	end
	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 4; i++)
			rd(8'h90 + 8'(4 * i), 8'hff);
		rd(8'ha4, 8'h03);
		bus(8'h9c, 1'b1, 8'h00);
		rd(8'h9c, 8'hf0);
		bus(8'h90, 1'b1, 8'hcf);
		bus(8'h90, 1'b1, 8'h64);
		rd(8'h90, 8'h44);
		rd(8'hb0, 8'h00);
		o = 8'hff;
		repeat (4) begin
			d = 8'($random(seed));
			o = mg(o, d);
			bus(8'h98, 1'b1, d);
			rd(8'h98, o);
		end
		for (int i = 0; i < 8; i++) begin
			pi(tt[i][10:4], tt[i][3:2]);
			chk(cv, tt[i][1:0]);
			chk(jv, {tt[i][1:0] == 2'b11, tt[i][1:0] != 2'b11});
		end
		bus(8'ha0, 1'b1, 8'h1b);
		rd(8'ha0, 8'h00);
		pi(7'h02, 2'h0);
		bus(8'ha0, 1'b1, 8'h1b);
		rd(8'ha0, 8'h18);
		bus(8'h94, 1'b1, 8'h7f);
		pi(7'h01, 2'h0);
		spi_req <= 1'b1;
		wt(1);
		chk(snap[20:0], {1'b0, 4'h7, 16'hffec});
		wt(2);
		chk(snap[22:21], 2'b01);
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		chk(irq_req, 1'b0);
		@(posedge hclk);
		bus(8'h94, 1'b1, 8'h3f);
		wt(1);
		chk(snap[19:16], 4'h7);
		wt(2);
		spi_req <= 1'b0;
		pi(7'h20, 2'h2);
		bus(8'h98, 1'b1, 8'h05);
		dly <= 4'h5;
		{timer_a_req, timer_b_req, async_serial_req} <= 3'h7;
		wt(1);
		chk(snap[19:16], 4'ha);
		wt(2);
		async_serial_req <= 1'b0;
		pi(7'h20, 2'h2);
		wt(1);
		chk(snap[19:16], 4'h8);
		wt(2);
		{timer_a_req, timer_b_req} <= 2'h0;
		bus(8'h90, 1'b1, 8'hdf);
		pi(7'h20, 2'h2);
		in_full_halt <= 1'b1;
		port_a_pins <= 4'h0;
		wt(1);
		chk(snap[19:0], {4'h2, 16'hfff6});
		@(negedge hclk);
		chk(halt_wake, 1'b1);
		wt(2);
		in_full_halt <= 1'b0;
		conclude;
	end
endmodule
